// [rtl/clk_cfg_pkg.sv]
// Constants and carriers for the clock output configuration register bank.
// Assumes a byte-wide register port driven by the serial-bus slave engine.
package clk_cfg_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_STOP_STATE = 8'h0B;
   localparam logic [7:0] OFF_OUT0_IMP = 8'h0C;
   localparam logic [7:0] OFF_OUT1_IMP = 8'h0D;
   localparam logic [7:0] OFF_EN0_PULL = 8'h0E;
   localparam logic [7:0] OFF_EN1_PULL = 8'h0F;
   localparam logic [7:0] OFF_PD_PULL = 8'h10;
   localparam logic [7:0] OFF_RESERVED = 8'h11;
   localparam logic [7:0] OFF_EN_POL = 8'h12;
   localparam logic [7:0] OFF_PD_POL = 8'h13;

   // ----------------------------------------
   // Field positions (low bit of each field)
   // ----------------------------------------
   localparam int POS_STOP = 0;
   localparam int POS_OUT0_IMP = 6;
   localparam int POS_OUT1_IMP = 2;
   localparam int POS_EN0_PULL = 6;
   localparam int POS_EN1_PULL = 2;
   localparam int POS_PD_PULL = 0;
   localparam int POS_EN0_POL = 3;
   localparam int POS_EN1_POL = 5;
   localparam int POS_PD_POL = 0;

   // ----------------------------------------
   // Reset values and fixed read values
   // ----------------------------------------
   localparam logic [1:0] RST_STOP = 2'h0;
   localparam logic [1:0] RST_IMP = 2'h2;
   localparam logic [1:0] RST_EN_PULL = 2'h1;
   localparam logic [1:0] RST_PD_PULL = 2'h2;
   localparam logic RST_POL = 1'b0;
   localparam logic [7:0] RSVD_READ = 8'h00;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [1:0] STOP_LOW_LOW = 2'h0;
   localparam logic [1:0] STOP_HIZ = 2'h1;
   localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
   localparam logic [1:0] STOP_LOW_HIGH = 2'h3;
   localparam logic [1:0] IMP_RESERVED = 2'h3;

   // Settings held by the bank
   typedef struct packed {
      logic [1:0] disabled_output_level_sel;
      logic [1:0] out0_impedance_sel;
      logic [1:0] out1_impedance_sel;
      logic [1:0] enable0_resistor_sel;
      logic [1:0] enable1_resistor_sel;
      logic [1:0] powerdown_pin_resistor_sel;
      logic enable0_active_level;
      logic enable1_active_level;
      logic powerdown_active_level;
   } cfg_type;

   // Output stage drive for one differential pair
   typedef struct packed {
      logic true_level;
      logic comp_level;
      logic drive_en;
   } diff_drive_type;

   // Pad resistor enables
   typedef struct packed {
      logic pull_up;
      logic pull_down;
   } pull_type;

   // Single-ended reference drive
   typedef struct packed {
      logic level;
      logic drive_en;
   } ref_drive_type;

endpackage : clk_cfg_pkg

// [rtl/clock_output_config_regs.sv]
// Register bank for stop state, impedance, pin pulls and control polarities.
// Assumes a byte-wide synchronous register port from the serial-bus slave
// engine, and pin levels already synchronous to mclk.
//
// Notes on behaviour
// (R1) Stop field byte 11[1:0] sets disabled pair: LL, HiZ, HL, LH; resets 00.
// (R2) Impedance selects: out0 byte12[7:6], out1 byte13[3:2]; 33/85/100, 11 reserved.
// (R3) Resistor selects for enables and powerdown pin: none, down, up, both.
// (R4) After reset enable resistor selects read 01, powerdown select reads 10.
// (R5) Enable polarity bits byte18 bits 3,5 reset 0; 0 enabled low, 1 high.
// (R6) Powerdown polarity byte19 bit0 resets 0; 0 powers down on low pin.
// (R7) Disabled reference output: 00 or 10 low, 01 HiZ, 11 high.
// (R8) Reserved bits and byte 17 ignore writes and read a fixed value.
module clock_output_config_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic output_enable_pin0,
   input wire logic output_enable_pin1,
   input wire logic power_good_powerdown_pin,
   input wire logic ref_enable,
   output clk_cfg_pkg::diff_drive_type differential_clock_out0,
   output clk_cfg_pkg::diff_drive_type differential_clock_out1,
   output logic [1:0] out0_impedance,
   output logic [1:0] out1_impedance,
   output clk_cfg_pkg::pull_type enable0_pull,
   output clk_cfg_pkg::pull_type enable1_pull,
   output clk_cfg_pkg::pull_type powerdown_pin_pull,
   output clk_cfg_pkg::ref_drive_type ref_out,
   output logic powerdown
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   clk_cfg_pkg::cfg_type cfg;
   clk_cfg_pkg::cfg_type next_cfg;

   // Splits a two-bit resistor code into pad enables
   function automatic clk_cfg_pkg::pull_type pull_decode(input logic [1:0] code);
      pull_decode.pull_up = code[1];
      pull_decode.pull_down = code[0];
   endfunction : pull_decode

   // Stopped pair levels; only the HiZ code releases the pads
   function automatic clk_cfg_pkg::diff_drive_type stop_decode(input logic [1:0] code);
      stop_decode.true_level = (code == clk_cfg_pkg::STOP_HIGH_LOW);
      stop_decode.comp_level = (code == clk_cfg_pkg::STOP_LOW_HIGH);
      stop_decode.drive_en = (code != clk_cfg_pkg::STOP_HIZ);
   endfunction : stop_decode

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   wire logic wr_stop = reg_wr && (reg_addr == clk_cfg_pkg::OFF_STOP_STATE);
   wire logic wr_imp0 = reg_wr && (reg_addr == clk_cfg_pkg::OFF_OUT0_IMP);
   wire logic wr_imp1 = reg_wr && (reg_addr == clk_cfg_pkg::OFF_OUT1_IMP);
   wire logic wr_en0p = reg_wr && (reg_addr == clk_cfg_pkg::OFF_EN0_PULL);
   wire logic wr_en1p = reg_wr && (reg_addr == clk_cfg_pkg::OFF_EN1_PULL);
   wire logic wr_pdp = reg_wr && (reg_addr == clk_cfg_pkg::OFF_PD_PULL);
   wire logic wr_enpol = reg_wr && (reg_addr == clk_cfg_pkg::OFF_EN_POL);
   wire logic wr_pdpol = reg_wr && (reg_addr == clk_cfg_pkg::OFF_PD_POL);
   wire logic [1:0] w_stop = reg_wdata[clk_cfg_pkg::POS_STOP +: 2];
   wire logic [1:0] w_imp0 = reg_wdata[clk_cfg_pkg::POS_OUT0_IMP +: 2];
   wire logic [1:0] w_imp1 = reg_wdata[clk_cfg_pkg::POS_OUT1_IMP +: 2];

   // Only the named fields take data; every other bit is dropped
   always_comb begin
      next_cfg = cfg;
      if (wr_stop) begin
         next_cfg.disabled_output_level_sel = w_stop; // R1
      end
      // Reserved impedance code is refused so the pad never sees it
      if (wr_imp0 && (w_imp0 != clk_cfg_pkg::IMP_RESERVED)) begin
         next_cfg.out0_impedance_sel = w_imp0; // R2
      end
      if (wr_imp1 && (w_imp1 != clk_cfg_pkg::IMP_RESERVED)) begin
         next_cfg.out1_impedance_sel = w_imp1; // R2
      end
      if (wr_en0p) begin
         next_cfg.enable0_resistor_sel = reg_wdata[clk_cfg_pkg::POS_EN0_PULL +: 2]; // R3
      end
      if (wr_en1p) begin
         next_cfg.enable1_resistor_sel = reg_wdata[clk_cfg_pkg::POS_EN1_PULL +: 2]; // R3
      end
      if (wr_pdp) begin
         next_cfg.powerdown_pin_resistor_sel = reg_wdata[clk_cfg_pkg::POS_PD_PULL +: 2]; // R3
      end
      if (wr_enpol) begin
         next_cfg.enable0_active_level = reg_wdata[clk_cfg_pkg::POS_EN0_POL]; // R5
         next_cfg.enable1_active_level = reg_wdata[clk_cfg_pkg::POS_EN1_POL]; // R5
      end
      if (wr_pdpol) begin
         next_cfg.powerdown_active_level = reg_wdata[clk_cfg_pkg::POS_PD_POL]; // R6
      end
   end

   // Configuration flops with their power-up values
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg.disabled_output_level_sel <= clk_cfg_pkg::RST_STOP; // R1
         cfg.out0_impedance_sel <= clk_cfg_pkg::RST_IMP;
         cfg.out1_impedance_sel <= clk_cfg_pkg::RST_IMP;
         cfg.enable0_resistor_sel <= clk_cfg_pkg::RST_EN_PULL; // R4
         cfg.enable1_resistor_sel <= clk_cfg_pkg::RST_EN_PULL; // R4
         cfg.powerdown_pin_resistor_sel <= clk_cfg_pkg::RST_PD_PULL; // R4
         cfg.enable0_active_level <= clk_cfg_pkg::RST_POL; // R5
         cfg.enable1_active_level <= clk_cfg_pkg::RST_POL; // R5
         cfg.powerdown_active_level <= clk_cfg_pkg::RST_POL; // R6
      end else begin
         cfg <= next_cfg;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [7:0] rd_mux;
   logic rd_map;

   // Reserved bits read zero; byte 17 reads its fixed value
   always_comb begin
      rd_mux = clk_cfg_pkg::RSVD_READ;
      rd_map = 1'b1;
      case (reg_addr)
         clk_cfg_pkg::OFF_STOP_STATE: rd_mux = {6'h00, cfg.disabled_output_level_sel};
         clk_cfg_pkg::OFF_OUT0_IMP: rd_mux = {cfg.out0_impedance_sel, 6'h00};
         clk_cfg_pkg::OFF_OUT1_IMP: rd_mux = {4'h0, cfg.out1_impedance_sel, 2'h0};
         clk_cfg_pkg::OFF_EN0_PULL: rd_mux = {cfg.enable0_resistor_sel, 6'h00};
         clk_cfg_pkg::OFF_EN1_PULL: rd_mux = {4'h0, cfg.enable1_resistor_sel, 2'h0};
         clk_cfg_pkg::OFF_PD_PULL: rd_mux = {6'h00, cfg.powerdown_pin_resistor_sel};
         clk_cfg_pkg::OFF_RESERVED: rd_mux = clk_cfg_pkg::RSVD_READ; // R8
         clk_cfg_pkg::OFF_EN_POL: rd_mux = {2'h0, cfg.enable1_active_level, 1'b0,
                                            cfg.enable0_active_level, 3'h0};
         clk_cfg_pkg::OFF_PD_POL: rd_mux = {7'h00, cfg.powerdown_active_level};
         default: rd_map = 1'b0;
      endcase
   end

   // Read data is registered one edge after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00; // R8
         reg_hit <= (reg_rd || reg_wr) && rd_map;
      end
   end

   // ----------------------------------------
   // Pin decode and pad controls
   // ----------------------------------------
   wire logic en0_active = (output_enable_pin0 == cfg.enable0_active_level); // R5
   wire logic en1_active = (output_enable_pin1 == cfg.enable1_active_level); // R5
   wire logic pd_active = (power_good_powerdown_pin == cfg.powerdown_active_level); // R6
   wire clk_cfg_pkg::diff_drive_type stop_drive = stop_decode(cfg.disabled_output_level_sel);
   // Running pair is flagged by drive enable with levels parked low
   wire clk_cfg_pkg::diff_drive_type run_drive = '{1'b0, 1'b0, 1'b1};
   wire logic [1:0] ref_code = cfg.disabled_output_level_sel;

   // Pad controls registered so every output comes from a flop
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         differential_clock_out0 <= '{1'b0, 1'b0, 1'b1};
         differential_clock_out1 <= '{1'b0, 1'b0, 1'b1};
         out0_impedance <= clk_cfg_pkg::RST_IMP;
         out1_impedance <= clk_cfg_pkg::RST_IMP;
         enable0_pull <= '{1'b0, 1'b1};
         enable1_pull <= '{1'b0, 1'b1};
         powerdown_pin_pull <= '{1'b1, 1'b0};
         ref_out <= '{1'b0, 1'b1};
         powerdown <= 1'b0;
      end else begin
         differential_clock_out0 <= en0_active ? run_drive : stop_drive; // R1
         differential_clock_out1 <= en1_active ? run_drive : stop_drive; // R1
         out0_impedance <= cfg.out0_impedance_sel; // R2
         out1_impedance <= cfg.out1_impedance_sel; // R2
         enable0_pull <= pull_decode(cfg.enable0_resistor_sel); // R3
         enable1_pull <= pull_decode(cfg.enable1_resistor_sel); // R3
         powerdown_pin_pull <= pull_decode(cfg.powerdown_pin_resistor_sel); // R3
         ref_out.level <= ref_enable ? 1'b0 : (ref_code == clk_cfg_pkg::STOP_LOW_HIGH); // R7
         ref_out.drive_en <= ref_enable || (ref_code != clk_cfg_pkg::STOP_HIZ); // R7
         powerdown <= pd_active; // R6
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_stop_hiz;
      @(posedge mclk) disable iff (rst)
      (!en0_active && cfg.disabled_output_level_sel == clk_cfg_pkg::STOP_HIZ)
         |=> !differential_clock_out0.drive_en;
   endproperty
   a_stop_hiz: assert property (p_stop_hiz) else $error("stopped pair not released"); // R1

   property p_stop_hl;
      @(posedge mclk) disable iff (rst)
      (!en1_active && cfg.disabled_output_level_sel == clk_cfg_pkg::STOP_HIGH_LOW)
         |=> differential_clock_out1.true_level && !differential_clock_out1.comp_level;
   endproperty
   a_stop_hl: assert property (p_stop_hl) else $error("stopped pair levels wrong"); // R1

   property p_imp_reserved;
      @(posedge mclk) disable iff (rst)
      wr_imp0 && w_imp0 == clk_cfg_pkg::IMP_RESERVED |=> $stable(cfg.out0_impedance_sel);
   endproperty
   a_imp_reserved: assert property (p_imp_reserved) else $error("reserved code taken"); // R2

   property p_imp_follow;
      @(posedge mclk) disable iff (rst)
      wr_imp1 && w_imp1 != clk_cfg_pkg::IMP_RESERVED |=> ##1 out1_impedance == $past(w_imp1, 2);
   endproperty
   a_imp_follow: assert property (p_imp_follow) else $error("impedance not applied"); // R2

   property p_pull_both;
      @(posedge mclk) disable iff (rst)
      cfg.powerdown_pin_resistor_sel == 2'h3 |=> powerdown_pin_pull.pull_up
         && powerdown_pin_pull.pull_down;
   endproperty
   a_pull_both: assert property (p_pull_both) else $error("pull decode wrong"); // R3

   property p_reset_pulls;
      @(posedge mclk) $fell(rst) |-> cfg.enable0_resistor_sel == clk_cfg_pkg::RST_EN_PULL
         && cfg.powerdown_pin_resistor_sel == clk_cfg_pkg::RST_PD_PULL;
   endproperty
   a_reset_pulls: assert property (p_reset_pulls) else $error("pull reset value wrong"); // R4

   property p_en_pol;
      @(posedge mclk) disable iff (rst)
      (cfg.enable0_active_level && output_enable_pin0) |=> differential_clock_out0.drive_en;
   endproperty
   a_en_pol: assert property (p_en_pol) else $error("enable polarity wrong"); // R5

   property p_pd_pol;
      @(posedge mclk) disable iff (rst)
      (power_good_powerdown_pin != cfg.powerdown_active_level) |=> !powerdown;
   endproperty
   a_pd_pol: assert property (p_pd_pol) else $error("powerdown polarity wrong"); // R6

   property p_ref_stop;
      @(posedge mclk) disable iff (rst)
      (!ref_enable && ref_code == clk_cfg_pkg::STOP_HIGH_LOW) |=> !ref_out.level
         && ref_out.drive_en;
   endproperty
   a_ref_stop: assert property (p_ref_stop) else $error("reference stop level wrong"); // R7

   property p_rsvd_read;
      @(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == clk_cfg_pkg::OFF_RESERVED |=> reg_rdata == clk_cfg_pkg::RSVD_READ;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte read wrong"); // R8

   c_stop_write: cover property (@(posedge mclk) disable iff (rst) wr_stop ##1 !en0_active);
   c_pd_enter: cover property (@(posedge mclk) disable iff (rst) $rose(powerdown));
   c_pol_flip: cover property (@(posedge mclk) disable iff (rst)
      wr_enpol ##2 $changed(differential_clock_out1));

endmodule : clock_output_config_regs

// [verification/smbus_host_model.sv]
// Register-port host that stands in for the serial-bus slave engine.
// Assumes callers enter its tasks just after a falling edge of mclk.
module smbus_host_model (
   input wire logic mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero; addr and data carry junk so stale values never pass
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hA5;
      reg_wdata = 8'h5A;
   end

   // One byte write: strobe held across exactly one rising edge
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(negedge mclk);
   endtask : write_byte

   // One byte read: answer stands one cycle after the strobe edge
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic h);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      d = reg_rdata;
      h = reg_hit;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge mclk);
   endtask : read_byte
endmodule : smbus_host_model

// [verification/tb.sv]
// Self-checking bench for the clock output configuration register bank.
// Assumes the host model above and the design's package; one clock domain.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr, reg_rd, reg_hit, rd_hit;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic output_enable_pin0 = 1'b0;
   logic output_enable_pin1 = 1'b0;
   logic power_good_powerdown_pin = 1'b1;
   logic ref_enable = 1'b1;
   clk_cfg_pkg::diff_drive_type differential_clock_out0, differential_clock_out1;
   logic [1:0] out0_impedance, out1_impedance;
   clk_cfg_pkg::pull_type enable0_pull, enable1_pull, powerdown_pin_pull;
   clk_cfg_pkg::ref_drive_type ref_out;
   logic powerdown;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   // Expected reset reads, offsets 0x0B..0x13
   logic [7:0] exp_rst [9] = '{8'h00, {clk_cfg_pkg::RST_IMP, 6'h00},
      {4'h0, clk_cfg_pkg::RST_IMP, 2'h0}, 8'h40, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00};
   // All-ones style writes and what survives the reserved bits
   logic [7:0] wr_val [9] = '{8'hFF, 8'h7F, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] wr_exp [9] = '{8'h03, 8'h40, 8'h04, 8'hC0, 8'h0C, 8'h03, 8'h00, 8'h28, 8'h01};
   // Disabled pair {true,comp,en} and reference {level,en} per stop code
   logic [2:0] exp_pair [4] = '{3'b001, 3'b000, 3'b101, 3'b011};
   logic [1:0] exp_ref [4] = '{2'b01, 2'b00, 2'b01, 2'b11};

   always #10 mclk = ~mclk;

   clock_output_config_regs clock_output_config_regs_inst (.mclk(mclk), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .output_enable_pin0(output_enable_pin0),
      .output_enable_pin1(output_enable_pin1),
      .power_good_powerdown_pin(power_good_powerdown_pin), .ref_enable(ref_enable),
      .differential_clock_out0(differential_clock_out0),
      .differential_clock_out1(differential_clock_out1), .out0_impedance(out0_impedance),
      .out1_impedance(out1_impedance), .enable0_pull(enable0_pull),
      .enable1_pull(enable1_pull), .powerdown_pin_pull(powerdown_pin_pull),
      .ref_out(ref_out), .powerdown(powerdown));

   smbus_host_model smbus_host_model_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Pad outputs lag a write by two cycles; wait three to be clear of it
   task automatic settle();
      repeat (3) @(negedge mclk);
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      smbus_host_model_inst.write_byte(a, d);
   endtask : wr

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset_values();
      for (int i = 0; i < 9; i++) begin
         smbus_host_model_inst.read_byte(8'(8'h0B + i), rd_val, rd_hit);
         check(rd_val, exp_rst[i], "reset read");
         check({7'h00, rd_hit}, 8'h01, "mapped hit");
      end
      check({6'h00, enable1_pull}, 8'h01, "enable pull reset");
      check({6'h00, powerdown_pin_pull}, 8'h02, "pd pull reset");
      check({7'h00, powerdown}, 8'h00, "pd reset polarity");
      check({5'h00, differential_clock_out0}, 8'h01, "running pair");
   endtask : test_reset_values

   task automatic test_access();
      for (int i = 0; i < 9; i++) begin
         wr(8'(8'h0B + i), wr_val[i]);
         smbus_host_model_inst.read_byte(8'(8'h0B + i), rd_val, rd_hit);
         check(rd_val, wr_exp[i], "masked readback");
      end
      wr(8'h0C, 8'hC0);
      smbus_host_model_inst.read_byte(8'h0C, rd_val, rd_hit);
      check(rd_val, 8'h40, "reserved impedance code kept old");
      foreach (wr_val[i]) begin
         // Every offset in this sweep lies outside 0x0B..0x13
         smbus_host_model_inst.read_byte(8'(8'h0A + 10 * i), rd_val, rd_hit);
         check(rd_val, 8'h00, "unmapped read");
         check({7'h00, rd_hit}, 8'h00, "unmapped hit");
      end
   endtask : test_access

   task automatic test_pads();
      for (int c = 0; c < 4; c++) begin
         wr(8'h0E, {2'(c), 6'h00});
         wr(8'h0F, {4'h0, 2'(c), 2'h0});
         wr(8'h10, {6'h00, 2'(c)});
         if (c < 3) wr(8'h0C, {2'(c), 6'h00});
         if (c < 3) wr(8'h0D, {4'h0, 2'(c), 2'h0});
         settle();
         check({6'h00, enable0_pull}, 8'(c), "enable0 pull");
         check({6'h00, enable1_pull}, 8'(c), "enable1 pull");
         check({6'h00, powerdown_pin_pull}, 8'(c), "pd pull");
         check({6'h00, out0_impedance}, 8'(c < 3 ? c : 2), "out0 impedance");
         check({6'h00, out1_impedance}, 8'(c < 3 ? c : 2), "out1 impedance");
      end
   endtask : test_pads

   task automatic test_stop();
      wr(8'h12, 8'h00);
      wr(8'h13, 8'h00);
      output_enable_pin0 = 1'b1;
      output_enable_pin1 = 1'b0;
      ref_enable = 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(8'h0B, 8'(c));
         settle();
         if (c == 1) begin
            check({7'h00, differential_clock_out0.drive_en}, 8'h00, "pair hiz");
            check({7'h00, ref_out.drive_en}, 8'h00, "ref hiz");
         end else begin
            check({5'h00, differential_clock_out0}, {5'h00, exp_pair[c]}, "pair stop");
            check({6'h00, ref_out}, {6'h00, exp_ref[c]}, "ref stop");
         end
         check({5'h00, differential_clock_out1}, 8'h01, "other pair runs");
      end
      ref_enable = 1'b1;
      settle();
      check({6'h00, ref_out}, 8'h01, "ref running");
   endtask : test_stop

   // Stop code 10 leaves the pair at true-high so disabled differs from running
   task automatic test_polarity();
      wr(8'h0B, 8'h02);
      wr(8'h12, 8'h08);
      settle();
      check({5'h00, differential_clock_out0}, 8'h01, "en0 high active, pin high");
      output_enable_pin0 = 1'b0;
      wr(8'h12, 8'h20);
      settle();
      check({5'h00, differential_clock_out1}, 8'h05, "en1 high active, pin low");
      output_enable_pin1 = 1'b1;
      settle();
      check({5'h00, differential_clock_out1}, 8'h01, "en1 high active, pin high");
      check({5'h00, differential_clock_out0}, 8'h01, "en0 low active, pin low");
   endtask : test_polarity

   task automatic test_powerdown();
      wr(8'h13, 8'h00);
      power_good_powerdown_pin = 1'b0;
      settle();
      check({7'h00, powerdown}, 8'h01, "pd on low pin");
      wr(8'h13, 8'h01);
      settle();
      check({7'h00, powerdown}, 8'h00, "no pd on low pin");
      power_good_powerdown_pin = 1'b1;
      settle();
      check({7'h00, powerdown}, 8'h01, "pd on high pin");
   endtask : test_powerdown

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   // Whole run is under two hundred cycles; the ceiling only catches a hang
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         $display("BAD t=%0t run did not finish", $time);
         wrap_up();
      end
   end

   initial begin
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      test_reset_values();
      test_access();
      test_pads();
      test_stop();
      test_polarity();
      test_powerdown();
      wrap_up();
   end
endmodule : tb
